/* File: irxm_pkg.sv */
/*
 * package for the isochronous receive channel mask block: register offsets,
 * field layout, reset values and the carrier types between the mask and the
 * receive-path filter.
 * assumes a 32-bit classic wishbone register bus with byte addresses.
 */
package irxm_pkg;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam int unsigned addr_width = 8;
   localparam logic [7:0] high_mask_set_offset = 8'h70;
   localparam logic [7:0] high_mask_clear_offset = 8'h74;
   localparam logic [7:0] low_mask_set_offset = 8'h78;
   localparam logic [7:0] low_mask_clear_offset = 8'h7c;

   // ************************************************************
   // field layout and reset values
   // ************************************************************
   localparam int unsigned mask_width = 32;
   localparam int unsigned channel_width = 6;
   localparam int unsigned channel_msb = 5;
   // mask contents are undefined to software; hardware parks them at zero
   localparam logic [31:0] mask_reset = 32'h0000_0000;
   localparam logic [31:0] read_unmapped = 32'h0000_0000;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic valid;
      logic iso;
      logic [5:0] channel;
   } irxm_rx_req_type;

   typedef struct packed {
      logic accept;
      logic discard;
   } irxm_rx_resp_type;

endpackage

/* File: irxm_chan_filter.sv */
/*
 * receive-path filter: looks up one packet's isochronous channel in the
 * 64-bit channel mask and answers accept or discard one cycle later.
 * assumes the request comes from logic on core_clk (no synchroniser).
 */
`timescale 1ns/1ps
`default_nettype none
module irxm_chan_filter (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // mask from the register bank
   input wire logic [31:0] mask_high,
   input wire logic [31:0] mask_low,
   // receive path
   input wire irxm_pkg::irxm_rx_req_type rx_req,
   output irxm_pkg::irxm_rx_resp_type rx_resp
);

   // ************************************************************
   // lookup
   // ************************************************************
   irxm_pkg::irxm_rx_resp_type state;
   irxm_pkg::irxm_rx_resp_type next_state;
   logic enabled;

   always_comb begin
      // channel bit 5 picks the upper half, bits 4:0 the position in it
      if (rx_req.channel[irxm_pkg::channel_msb]) begin
         enabled = mask_high[rx_req.channel[4:0]];
      end else begin
         enabled = mask_low[rx_req.channel[4:0]];
      end
      next_state.accept = 1'b0;
      next_state.discard = 1'b0;
      if (rx_req.valid) begin
         // non-isochronous traffic is not subject to the channel mask
         next_state.accept = !rx_req.iso || enabled;
         next_state.discard = rx_req.iso && !enabled;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rx_resp = state;

endmodule
`default_nettype wire

/* File: irxm_channel_mask.sv */
/*
 * isochronous receive channel mask: two 32-bit masks, each reached through
 * a set address and a clear address over classic wishbone, and the filter
 * that gates received isochronous packets by channel number.
 * assumes a single 100 MHz core_clk; a classic single-cycle master that
 * holds each request until it sees ack and idles at least one cycle between
 * accesses; and a receive path that drives rx_req from core_clk. the masks
 * are brought out so the rest of the receive logic can see open channels.
 */
// Local design decision: register access over Wishbone.
// Contract
// - upper bit i enables channel 32 plus i
// - lower bit i enables channel i
// - lower mask has set and clear addresses
// - discard isochronous channels 0-31 unless lower bit set
// - upper mask set/clear gates channels 32-63
// - reading set or clear returns mask
`timescale 1ns/1ps
`default_nettype none
module irxm_channel_mask (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // receive path
   input wire irxm_pkg::irxm_rx_req_type rx_req,
   output irxm_pkg::irxm_rx_resp_type rx_resp,
   // mask state for the rest of the receive logic
   output logic [31:0] mask_high,
   output logic [31:0] mask_low
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [31:0] high;
      logic [31:0] low;
      logic [31:0] rdata;
      logic ack;
   } irxm_state_type;

   // which mask register an address names; all zero for an unmapped address
   typedef struct packed {
      logic high_set;
      logic high_clear;
      logic low_set;
      logic low_clear;
   } irxm_target_type;

   irxm_state_type state;
   irxm_state_type next_state;

   // ************************************************************
   // helpers
   // ************************************************************
   // expands byte enables to a bit mask; unselected lanes write nothing
   function automatic logic [31:0] lane_bits(input logic [3:0] sel);
      logic [31:0] bits;
      bits = '0;
      for (int i = 0; i < 4; i++) begin
         bits[i*8 +: 8] = {8{sel[i]}};
      end
      return bits;
   endfunction

   // set form: ones set, zeros keep
   function automatic logic [31:0] apply_set(input logic [31:0] cur,
                                             input logic [31:0] wr);
      return cur | wr;
   endfunction

   // clear form: ones clear, zeros keep
   function automatic logic [31:0] apply_clear(input logic [31:0] cur,
                                               input logic [31:0] wr);
      return cur & ~wr;
   endfunction

   // shared by the write path and the read path so both agree on the target;
   // an address is matched in full, so near aliases read as unmapped
   function automatic irxm_target_type decode_target(input logic [7:0] adr);
      irxm_target_type hit;
      hit = '0;
      if (adr == irxm_pkg::high_mask_set_offset) begin
         hit.high_set = 1'b1;
      end else if (adr == irxm_pkg::high_mask_clear_offset) begin
         hit.high_clear = 1'b1;
      end else if (adr == irxm_pkg::low_mask_set_offset) begin
         hit.low_set = 1'b1;
      end else if (adr == irxm_pkg::low_mask_clear_offset) begin
         hit.low_clear = 1'b1;
      end
      return hit;
   endfunction

   // both addresses of a mask read the mask itself
   function automatic logic [31:0] read_word(input irxm_target_type hit,
                                             input logic [31:0] high_word,
                                             input logic [31:0] low_word);
      logic [31:0] word;
      word = irxm_pkg::read_unmapped;
      if (hit.high_set || hit.high_clear) begin
         word = high_word;
      end else if (hit.low_set || hit.low_clear) begin
         word = low_word;
      end
      return word;
   endfunction

   // one mask behind its two addresses; zero bits keep their value
   function automatic logic [31:0] update_mask(input logic [31:0] cur,
                                               input logic set_hit,
                                               input logic clear_hit,
                                               input logic [31:0] wr);
      logic [31:0] word;
      word = cur;
      if (set_hit) begin
         word = apply_set(cur, wr);
      end else if (clear_hit) begin
         word = apply_clear(cur, wr);
      end
      return word;
   endfunction

   // ************************************************************
   // bus request decode
   // ************************************************************
   logic request;
   logic write_now;
   logic [31:0] wr_bits;
   irxm_target_type target;

   // ************************************************************
   // bus slave and mask update
   // ************************************************************
   always_comb begin
      request = wb_cyc_i && wb_stb_i;
      target = decode_target(wb_adr_i);
      wr_bits = wb_dat_i & lane_bits(wb_sel_i);
      // a write lands at the edge where the master sees ack, so a read that
      // follows it already returns the new mask
      write_now = request && state.ack && wb_we_i;
      next_state = state;
      // ack one cycle after the request, dropped the cycle after; a master
      // that keeps stb up past ack sees ack low before its next access
      next_state.ack = request && !state.ack;
      if (write_now) begin
         next_state.high = update_mask(state.high, target.high_set, target.high_clear,
                                       wr_bits);
         next_state.low = update_mask(state.low, target.low_set, target.low_clear,
                                      wr_bits);
      end
      // read data is captured together with ack and stands until replaced
      if (request && !state.ack) begin
         next_state.rdata = read_word(target, state.high, state.low);
      end
   end

   // the masks mean nothing to software after reset; zeroing them only keeps
   // the filter away from unknowns, and software clears both masks itself
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state.high <= irxm_pkg::mask_reset;
         state.low <= irxm_pkg::mask_reset;
         state.rdata <= '0;
         state.ack <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign wb_ack_o = state.ack;
   assign wb_dat_o = state.rdata;
   assign mask_high = state.high;
   assign mask_low = state.low;

   // ************************************************************
   // channel view
   // ************************************************************
   // one enable per channel number, in channel order, so the bit-to-channel
   // mapping lives in one place and the filter only ever sees channel order
   logic [63:0] channel_on;

   for (genvar i = 0; i < irxm_pkg::mask_width; i++) begin : g_lower
      assign channel_on[i] = state.low[i];
   end
   // upper mask bit i is channel 32 plus i
   for (genvar i = 0; i < irxm_pkg::mask_width; i++) begin : g_upper
      assign channel_on[irxm_pkg::mask_width + i] = state.high[i];
   end

   // ************************************************************
   // receive filter
   // ************************************************************
   irxm_chan_filter u_filter (
      .core_clk(core_clk),
      .reset(reset),
      .mask_high(channel_on[63:32]),
      .mask_low(channel_on[31:0]),
      .rx_req(rx_req),
      .rx_resp(rx_resp)
   );

endmodule
`default_nettype wire

/* File: irxm_channel_mask_asserts.sv */
/* checker for the channel mask block, bound to its top ports.
   assumes irxm_pkg is compiled first and one core_clk domain. */
`timescale 1ns/1ps
`default_nettype none
module irxm_channel_mask_asserts (
   // bus and mask
   input wire logic core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o, mask_high, mask_low,
   // receive path
   input wire irxm_pkg::irxm_rx_req_type rx_req,
   input wire irxm_pkg::irxm_rx_resp_type rx_resp
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire logic [31:0] wr = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic wa = wb_ack_o && wb_we_i;
   logic bit_on;
   // mask bit seen at the edge that takes the packet
   always_ff @(posedge core_clk) begin
      bit_on <= rx_req.channel[5] ? mask_high[rx_req.channel[4:0]] : mask_low[rx_req.channel[4:0]];
   end
   property p_low_set; wa && wb_adr_i == 8'h78 |=> mask_low == ($past(mask_low) | $past(wr)); endproperty
   property p_low_clr; wa && wb_adr_i == 8'h7c |=> mask_low == ($past(mask_low) & ~$past(wr)); endproperty
   property p_high; wa && wb_adr_i[7:3] == 5'h0e |=> mask_high == (($past(wb_adr_i) == 8'h70) ?
      ($past(mask_high) | $past(wr)) : ($past(mask_high) & ~$past(wr))); endproperty
   property p_read; wb_ack_o && !wb_we_i && wb_adr_i[7:4] == 4'h7 |->
      wb_dat_o == (wb_adr_i[3] ? mask_low : mask_high); endproperty
   property p_keep; !wa |=> $stable(mask_low) && $stable(mask_high); endproperty
   property p_low_rx; rx_req.valid && rx_req.iso && !rx_req.channel[5] |=>
      rx_resp.accept == bit_on && rx_resp.discard != bit_on; endproperty
   property p_high_rx; rx_req.valid && rx_req.iso && rx_req.channel[5] |=>
      rx_resp.accept == bit_on && rx_resp.discard != bit_on; endproperty
   property p_rx_plain; rx_req.valid && !rx_req.iso |=>
      rx_resp.accept && !rx_resp.discard; endproperty
   property p_rx_idle; !rx_req.valid |=> !rx_resp.accept && !rx_resp.discard; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_low_set:
      assert property (p_low_set) else $error("low mask set wrong");
   a_low_clr:
      assert property (p_low_clr) else $error("low mask clear wrong");
   a_high:
      assert property (p_high) else $error("high mask update wrong");
   a_read:
      assert property (p_read) else $error("mask read wrong");
   a_keep:
      assert property (p_keep) else $error("mask changed without write");
   a_low_rx:
      assert property (p_low_rx) else $error("lower channel filter wrong");
   a_high_rx:
      assert property (p_high_rx) else $error("upper channel filter wrong");
   a_rx_plain:
      assert property (p_rx_plain) else $error("non-isochronous packet not accepted");
   a_rx_idle:
      assert property (p_rx_idle) else $error("filter answered without a packet");
   a_ack_pulse:
      assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_due:
      assert property (p_ack_due) else $error("ack missing after request");
   cover property (wa && wb_adr_i == 8'h74);
   cover property (wb_ack_o && !wb_we_i);
   cover property (rx_resp.discard);
endmodule
bind irxm_channel_mask irxm_channel_mask_asserts u_chk (.core_clk, .reset, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
   .mask_high, .mask_low, .rx_req, .rx_resp);
`default_nettype wire

/* File: irxm_rx_source.sv */
/* model of the link receive path: hands one packet header per send.
   assumes send is driven on core_clk. */
`timescale 1ns/1ps
`default_nettype none
module irxm_rx_source (
   input wire logic core_clk,
   input wire logic send, iso,
   input wire logic [5:0] channel,
   output var irxm_pkg::irxm_rx_req_type rx_req
);
   initial rx_req = '0;
   // idle header lines keep moving so a filter ignoring valid shows up
   always @(posedge core_clk) begin
      rx_req.valid <= send;
      rx_req.iso <= send ? iso : ~rx_req.iso;
      rx_req.channel <= send ? channel : ~rx_req.channel;
   end
endmodule
`default_nettype wire

/* File: irxm_channel_mask_tb.sv */
/* self-checking bench: wishbone register access and packet filtering.
   assumes the checker and the receive-path model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module irxm_channel_mask_tb;
   logic core_clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic send = 1'b0, iso = 1'b0;
   logic [5:0] chan = 6'h00;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, dat_o, rdat, mh, ml;
   irxm_pkg::irxm_rx_req_type rx_req;
   irxm_pkg::irxm_rx_resp_type rx_resp;
   int n_mismatch = 0, compares = 0, cycles = 0;
   always #5 core_clk = ~core_clk;
   irxm_rx_source far (.core_clk, .send, .iso, .channel(chan), .rx_req);
   irxm_channel_mask dut (.core_clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .rx_req, .rx_resp, .mask_high(mh), .mask_low(ml));
   task automatic chk(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d);
      @(posedge core_clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
      do @(posedge core_clk); while (ack !== 1'b1);
      rdat = dat_o;
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 4'h0, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic rx(input logic i, input logic [5:0] c, input logic acc);
      @(posedge core_clk);
      {send, iso, chan} <= {1'b1, i, c};
      @(posedge core_clk);
      send <= 1'b0;
      @(posedge core_clk);
      #1 chk({30'h0, rx_resp}, {30'h0, acc, !acc});
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // the whole run needs under a hundred cycles
   always @(posedge core_clk) begin
      if (++cycles == 2000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      // mask contents are undefined after reset: software clears both first
      bus(1'b1, 8'h74, 4'hf, 32'hffff_ffff);
      bus(1'b1, 8'h7c, 4'hf, 32'hffff_ffff);
      rd(8'h70, 32'h0000_0000);
      bus(1'b1, 8'h78, 4'hf, 32'ha5a5_0f0f);
      rd(8'h78, 32'ha5a5_0f0f);
      bus(1'b1, 8'h7c, 4'hf, 32'h0000_0f01);
      rd(8'h7c, 32'ha5a5_000e);
      bus(1'b1, 8'h78, 4'h2, 32'hffff_ffff);
      rd(8'h7c, 32'ha5a5_ff0e);
      bus(1'b1, 8'h70, 4'hf, 32'h8000_0003);
      bus(1'b1, 8'h74, 4'hf, 32'h0000_0001);
      rd(8'h74, 32'h8000_0002);
      rd(8'h40, 32'h0000_0000);
      chk(mh, 32'h8000_0002);
      chk(ml, 32'ha5a5_ff0e);
      $display("register tests done");
      rx(1'b1, 6'h01, 1'b1);
      rx(1'b1, 6'h00, 1'b0);
      rx(1'b1, 6'h08, 1'b1);
      rx(1'b1, 6'h1f, 1'b1);
      rx(1'b1, 6'h1e, 1'b0);
      rx(1'b1, 6'h3f, 1'b1);
      rx(1'b1, 6'h20, 1'b0);
      rx(1'b1, 6'h21, 1'b1);
      rx(1'b0, 6'h20, 1'b1);
      $display("receive tests done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
